/* File: include/tms_pkg.sv */
// package: register map, field positions, reset values and carriers for the monitor status block
package tms_pkg;

  // -----------------------------------------------------------------
  // pointer addresses
  // -----------------------------------------------------------------
  localparam logic [7:0] PTR_STATUS = 8'h02;
  localparam logic [7:0] PTR_CFG1_RD = 8'h03;
  localparam logic [7:0] PTR_CFG1_WR = 8'h09;
  localparam logic [7:0] PTR_HYST = 8'h21;
  localparam logic [7:0] PTR_ONESHOT = 8'h0F;

  // -----------------------------------------------------------------
  // reset values
  // -----------------------------------------------------------------
  localparam logic [7:0] CFG1_RST = 8'h00;
  localparam logic [7:0] HYST_RST = 8'h0A;
  localparam logic [7:0] STATUS_RST = 8'h00;

  // -----------------------------------------------------------------
  // configuration one fields
  // -----------------------------------------------------------------
  localparam int CFG_MASK_BIT = 7;
  localparam int CFG_HALT_BIT = 6;
  localparam int CFG_PINSEL_BIT = 5;
  localparam int CFG_RANGE_BIT = 2;
  localparam logic [7:0] CFG1_WMASK = 8'hE4;

  // -----------------------------------------------------------------
  // status fields, single-remote layout
  // -----------------------------------------------------------------
  localparam int ST_BUSY = 7;
  localparam int ST_LHI = 6;
  localparam int ST_LLO = 5;
  localparam int ST_RHI = 4;
  localparam int ST_RLO = 3;
  localparam int ST_OPEN = 2;
  localparam int ST_RCRIT = 1;
  localparam int ST_LCRIT = 0;
  // merged layout positions
  localparam int STM_HI = 4;
  localparam int STM_LO = 3;
  localparam int STM_CRIT = 1;

  // -----------------------------------------------------------------
  // timing
  // -----------------------------------------------------------------
  localparam int CLK_HZ = 40_000_000;
  localparam int FIRST_CONV_US = 100;
  localparam int FIRST_CONV_CYC = (FIRST_CONV_US * (CLK_HZ / 1_000_000));
  localparam int START_DELAY_CYC = 16;
  localparam logic [3:0] ALERT_CNT_RST = 4'h1;

  // -----------------------------------------------------------------
  // carriers
  // -----------------------------------------------------------------
  typedef struct packed {
    logic we;
    logic re;
    logic [7:0] ptr;
    logic [7:0] wdata;
  } tms_reg_req_s;

  typedef struct packed {
    logic valid;
    logic remote;
    logic [1:0] chan;
    logic open;
    logic [7:0] temp;
    logic [7:0] high_lim;
    logic [7:0] low_lim;
    logic [7:0] crit_lim;
  } tms_result_s;

  typedef enum logic [1:0] {
    TMS_IDLE,
    TMS_CONV
  } tms_conv_e;

endpackage

/* File: verilog/tms_hyst_cmp.sv */
// module: live hysteretic comparator updated at the end of each valid conversion of its own channel
`timescale 1ns/1ps
module tms_hyst_cmp
  import tms_pkg::*;
(
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic update_i,
  input wire logic [7:0] temp_i,
  input wire logic [7:0] limit_i,
  input wire logic [7:0] hyst_i,
  output logic flag_o
);

  logic [8:0] release_lvl;

  // release point clamps at zero so a large hysteresis never wraps
  always_comb
  begin
    release_lvl = {1'b0, limit_i} - {1'b0, hyst_i};
    if (release_lvl[8])
    begin
      release_lvl = 9'h000;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      flag_o <= 1'b0;
    end
    else if (update_i)
    begin
      if (temp_i > limit_i)
      begin
        flag_o <= 1'b1;
      end
      else if ({1'b0, temp_i} <= release_lvl)
      begin
        flag_o <= 1'b0;
      end
    end
  end

endmodule

/* File: verilog/tms_sticky.sv */
// module: sticky event flag, set by an event, cleared by a status read when the cause is gone
`timescale 1ns/1ps
module tms_sticky
  import tms_pkg::*;
(
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic set_i,
  input wire logic cause_i,
  input wire logic clear_i,
  output logic flag_o,
  output logic rise_o
);

  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      flag_o <= 1'b0;
    end
    else if (set_i)
    begin
      flag_o <= 1'b1;
    end
    else if (clear_i && !cause_i)
    begin
      flag_o <= 1'b0;
    end
  end

  // pulse while a set meets the flag at 0, one cycle before the flag reads 1
  assign rise_o = set_i && !flag_o;

endmodule

/* File: verilog/tms_status_cfg.sv */
// module: status flags, configuration one, hysteresis and attention pin of the monitor
//
// Overview of operation
// - busy flag follows conversion, first soon after reset
// - open sensor sticky, checked only on remote
// - critical flag above limit, clears with hysteresis
// - select 0: upper flags sticky events
// - select 1: upper flags live hysteretic comparators
// - lower flags sticky in every pin mode
// - sticky held until read, cause gone
// - live flags untouched by status read
// - attention latch released only by alert response
// - attention asserted on sticky flag rising
// - merged variant: single upper, lower, critical
// - merged upper is live in secondary mode
// - status at 02h, writes ignored
// - config one written 09h, read 03h
// - suppress bit holds pin high in select 0 only, keeps status
// - attention needs consecutive out-of-limit count
// - halt stops conversions; single shot allowed
// - secondary mode: pin low on upper flag
// - range bit selects standard or extended
// - reserved bits zero, config resets 00h
// - single-remote status bit order
// - hysteresis register at 21h, reset 0Ah
`timescale 1ns/1ps
module tms_status_cfg
  import tms_pkg::*;
#(
  parameter bit MERGED = 1'b0,
  parameter int FIRST_DELAY = START_DELAY_CYC
)
(
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire tms_reg_req_s req_i,
  input wire logic alert_resp_i,
  input wire logic [3:0] alert_count_i,
  input wire logic conv_done_i,
  input wire tms_result_s result_i,
  output logic [7:0] rdata_o,
  output logic conv_busy_o,
  output logic conv_start_o,
  output logic extended_range_o,
  output logic pin_o,
  output logic pin_oe_o
);

  // -----------------------------------------------------------------
  // registers
  // -----------------------------------------------------------------
  logic [7:0] general_configuration_one;
  logic [7:0] hysteresis;
  logic [7:0] comparator_status_flags;
  logic suppress_alert;
  logic halt_conversions;
  logic pin_function_select;
  logic status_read;
  logic cfg_write;

  assign status_read = req_i.re && (req_i.ptr == PTR_STATUS);
  assign cfg_write = req_i.we && (req_i.ptr == PTR_CFG1_WR);
  assign suppress_alert = general_configuration_one[CFG_MASK_BIT];
  assign halt_conversions = general_configuration_one[CFG_HALT_BIT];
  assign pin_function_select = general_configuration_one[CFG_PINSEL_BIT];

  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      general_configuration_one <= CFG1_RST;
    end
    else if (cfg_write)
    begin
      general_configuration_one <= req_i.wdata & CFG1_WMASK;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      hysteresis <= HYST_RST;
    end
    else if (req_i.we && (req_i.ptr == PTR_HYST))
    begin
      hysteresis <= req_i.wdata;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      extended_range_o <= 1'b0;
    end
    else
    begin
      extended_range_o <= general_configuration_one[CFG_RANGE_BIT];
    end
  end

  // -----------------------------------------------------------------
  // conversion sequencing
  // -----------------------------------------------------------------
  tms_conv_e conv_state;
  logic [15:0] start_cnt;
  logic first_done;
  logic oneshot_req;
  logic halt_now;

  // a write that sets halt acts on the edge that takes it, so no start slips through
  assign halt_now = cfg_write ? req_i.wdata[CFG_HALT_BIT] : halt_conversions;

  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      oneshot_req <= 1'b0;
    end
    else if (req_i.we && (req_i.ptr == PTR_ONESHOT))
    begin
      oneshot_req <= 1'b1;
    end
    else if (conv_start_o)
    begin
      oneshot_req <= 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      start_cnt <= 16'h0000;
      first_done <= 1'b0;
    end
    else if (!first_done)
    begin
      start_cnt <= start_cnt + 16'h0001;
      if (start_cnt >= 16'(FIRST_DELAY - 1))
      begin
        first_done <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      conv_state <= TMS_IDLE;
      conv_start_o <= 1'b0;
      conv_busy_o <= 1'b0;
    end
    else
    begin
      conv_start_o <= 1'b0;
      case (conv_state)
        TMS_IDLE:
        begin
          conv_busy_o <= 1'b0;
          if (first_done && (!halt_now || oneshot_req))
          begin
            conv_state <= TMS_CONV;
            conv_start_o <= 1'b1;
            conv_busy_o <= 1'b1;
          end
        end
        TMS_CONV:
        begin
          if (cfg_write && req_i.wdata[CFG_HALT_BIT] && !oneshot_req)
          begin
            conv_state <= TMS_IDLE;
            conv_busy_o <= 1'b0;
          end
          else if (conv_done_i)
          begin
            conv_state <= TMS_IDLE;
            conv_busy_o <= 1'b0;
          end
        end
        default:
        begin
          conv_state <= TMS_IDLE;
          conv_busy_o <= 1'b0;
        end
      endcase
    end
  end

  // -----------------------------------------------------------------
  // per-conversion compare, result remote bit selects local or remote, chan unused
  // -----------------------------------------------------------------
  logic upd;
  logic over_hi;
  logic under_lo;
  logic upd_loc;
  logic upd_rem;

  assign upd = conv_done_i && result_i.valid;
  assign over_hi = result_i.temp > result_i.high_lim;
  assign under_lo = result_i.temp < result_i.low_lim;
  assign upd_loc = upd && !result_i.remote;
  assign upd_rem = upd && result_i.remote;

  // live comparators: critical and secondary upper
  logic lcrit_live, rcrit_live, lhi_live, rhi_live;

  tms_hyst_cmp u_lcrit (.clk_i(clk_i), .arst_n_i(arst_n_i), .update_i(upd_loc),
    .temp_i(result_i.temp), .limit_i(result_i.crit_lim), .hyst_i(hysteresis),
    .flag_o(lcrit_live));
  tms_hyst_cmp u_rcrit (.clk_i(clk_i), .arst_n_i(arst_n_i), .update_i(upd_rem),
    .temp_i(result_i.temp), .limit_i(result_i.crit_lim), .hyst_i(hysteresis),
    .flag_o(rcrit_live));
  tms_hyst_cmp u_lhi (.clk_i(clk_i), .arst_n_i(arst_n_i), .update_i(upd_loc),
    .temp_i(result_i.temp), .limit_i(result_i.high_lim), .hyst_i(hysteresis),
    .flag_o(lhi_live));
  tms_hyst_cmp u_rhi (.clk_i(clk_i), .arst_n_i(arst_n_i), .update_i(upd_rem),
    .temp_i(result_i.temp), .limit_i(result_i.high_lim), .hyst_i(hysteresis),
    .flag_o(rhi_live));

  // cause levels held per channel for the clear-on-read check
  logic lhi_cause, llo_cause, rhi_cause, rlo_cause, open_cause;

  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      lhi_cause <= 1'b0;
      llo_cause <= 1'b0;
      rhi_cause <= 1'b0;
      rlo_cause <= 1'b0;
      open_cause <= 1'b0;
    end
    else
    begin
      if (upd_loc)
      begin
        lhi_cause <= over_hi;
        llo_cause <= under_lo;
      end
      if (upd_rem)
      begin
        rhi_cause <= over_hi && !result_i.open;
        rlo_cause <= under_lo && !result_i.open;
        open_cause <= result_i.open;
      end
    end
  end

  // -----------------------------------------------------------------
  // sticky flags
  // -----------------------------------------------------------------
  logic lhi_st, llo_st, rhi_st, rlo_st, open_st;
  logic lhi_rise, llo_rise, rhi_rise, rlo_rise, open_rise;
  logic sticky_hi_en;

  assign sticky_hi_en = !pin_function_select;

  tms_sticky u_lhi_st (.clk_i(clk_i), .arst_n_i(arst_n_i),
    .set_i(upd_loc && over_hi && sticky_hi_en), .cause_i(lhi_cause && sticky_hi_en),
    .clear_i(status_read), .flag_o(lhi_st), .rise_o(lhi_rise));
  tms_sticky u_llo_st (.clk_i(clk_i), .arst_n_i(arst_n_i),
    .set_i(upd_loc && under_lo), .cause_i(llo_cause),
    .clear_i(status_read), .flag_o(llo_st), .rise_o(llo_rise));
  tms_sticky u_rhi_st (.clk_i(clk_i), .arst_n_i(arst_n_i),
    .set_i(upd_rem && over_hi && !result_i.open && sticky_hi_en),
    .cause_i(rhi_cause && sticky_hi_en),
    .clear_i(status_read), .flag_o(rhi_st), .rise_o(rhi_rise));
  tms_sticky u_rlo_st (.clk_i(clk_i), .arst_n_i(arst_n_i),
    .set_i(upd_rem && under_lo && !result_i.open), .cause_i(rlo_cause),
    .clear_i(status_read), .flag_o(rlo_st), .rise_o(rlo_rise));
  tms_sticky u_open_st (.clk_i(clk_i), .arst_n_i(arst_n_i),
    .set_i(upd_rem && result_i.open), .cause_i(open_cause),
    .clear_i(status_read), .flag_o(open_st), .rise_o(open_rise));

  // -----------------------------------------------------------------
  // status assembly
  // -----------------------------------------------------------------
  logic local_upper_flag, remote_upper_flag;
  logic [7:0] next_status;

  assign local_upper_flag = pin_function_select ? lhi_live : lhi_st;
  assign remote_upper_flag = pin_function_select ? rhi_live : rhi_st;

  always_comb
  begin
    next_status = STATUS_RST;
    next_status[ST_BUSY] = conv_busy_o;
    if (MERGED)
    begin
      next_status[STM_HI] = local_upper_flag | remote_upper_flag;
      next_status[STM_LO] = llo_st | rlo_st;
      next_status[ST_OPEN] = open_st;
      next_status[STM_CRIT] = lcrit_live | rcrit_live;
    end
    else
    begin
      next_status[ST_LHI] = local_upper_flag;
      next_status[ST_LLO] = llo_st;
      next_status[ST_RHI] = remote_upper_flag;
      next_status[ST_RLO] = rlo_st;
      next_status[ST_OPEN] = open_st;
      next_status[ST_RCRIT] = rcrit_live;
      next_status[ST_LCRIT] = lcrit_live;
    end
  end

  assign comparator_status_flags = next_status;

  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      rdata_o <= 8'h00;
    end
    else if (req_i.re)
    begin
      case (req_i.ptr)
        PTR_STATUS: rdata_o <= comparator_status_flags;
        PTR_CFG1_RD: rdata_o <= general_configuration_one;
        PTR_HYST: rdata_o <= hysteresis;
        default: rdata_o <= 8'h00;
      endcase
    end
  end

  // -----------------------------------------------------------------
  // consecutive out-of-limit counters and attention pin
  // -----------------------------------------------------------------
  logic [3:0] loc_cnt, rem_cnt;
  logic loc_hit, rem_hit;
  logic loc_reach, rem_reach;
  logic alert_latched;
  logic any_rise;
  logic [3:0] need;

  assign need = (alert_count_i == 4'h0) ? ALERT_CNT_RST : alert_count_i;
  assign any_rise = lhi_rise | llo_rise | rhi_rise | rlo_rise | open_rise;

  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      loc_cnt <= 4'h0;
      rem_cnt <= 4'h0;
    end
    else
    begin
      if (upd_loc)
      begin
        loc_cnt <= (over_hi || under_lo) ? ((loc_cnt == 4'hF) ? loc_cnt : loc_cnt + 4'h1)
          : 4'h0;
      end
      if (upd_rem)
      begin
        rem_cnt <= (over_hi || under_lo || result_i.open)
          ? ((rem_cnt == 4'hF) ? rem_cnt : rem_cnt + 4'h1) : 4'h0;
      end
    end
  end

  assign loc_hit = upd_loc && (over_hi || under_lo)
    && (({1'b0, loc_cnt} + 5'h01) >= {1'b0, need});
  assign rem_hit = upd_rem && (over_hi || under_lo || result_i.open)
    && (({1'b0, rem_cnt} + 5'h01) >= {1'b0, need});
  // in select 0 the run reaching the count alerts even when the flag rose earlier
  assign loc_reach = upd_loc && (over_hi || under_lo) && ((loc_cnt + 4'h1) == need);
  assign rem_reach = upd_rem && (over_hi || under_lo || result_i.open)
    && ((rem_cnt + 4'h1) == need);

  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      alert_latched <= 1'b0;
    end
    else if ((any_rise && (loc_hit || rem_hit))
      || (!pin_function_select && (loc_reach || rem_reach)))
    begin
      alert_latched <= 1'b1;
    end
    else if (alert_resp_i)
    begin
      alert_latched <= 1'b0;
    end
  end

  // open-drain pin: enable high pulls the line low
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      pin_oe_o <= 1'b0;
      pin_o <= 1'b0;
    end
    else
    begin
      pin_o <= 1'b0;
      if (pin_function_select)
      begin
        pin_oe_o <= local_upper_flag | remote_upper_flag;
      end
      else
      begin
        pin_oe_o <= alert_latched && !suppress_alert;
      end
    end
  end

endmodule

/* File: tb/tms_status_checker.sv */
// checker: port-level assertions for the status and configuration block
`timescale 1ns/1ps
module tms_status_checker
  import tms_pkg::*;
#(
  parameter int FIRST_DELAY = START_DELAY_CYC
)
(
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire tms_reg_req_s req_i,
  input wire logic alert_resp_i,
  input wire logic [3:0] alert_count_i,
  input wire logic conv_done_i,
  input wire tms_result_s result_i,
  input wire logic [7:0] rdata_o,
  input wire logic conv_busy_o,
  input wire logic conv_start_o,
  input wire logic extended_range_o,
  input wire logic pin_o,
  input wire logic pin_oe_o
);
  localparam int LIMIT = FIRST_DELAY + 4;
  logic [7:0] cfg_q;
  logic [7:0] cfg_d;
  logic shot_q;
  logic started;
  logic [15:0] cyc;
  // ---------------------------------------------------------------
  // mirrors of configuration one and of the one-shot permission
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      cfg_q <= 8'h00;
      cfg_d <= 8'h00;
    end
    else
    begin
      if (req_i.we && req_i.ptr == PTR_CFG1_WR)
        cfg_q <= req_i.wdata & CFG1_WMASK;
      cfg_d <= cfg_q;
    end
  end
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      shot_q <= 1'b0;
    else if (req_i.we && req_i.ptr == PTR_ONESHOT)
      shot_q <= 1'b1;
    else if (conv_start_o)
      shot_q <= 1'b0;
  end
  // cycles since reset, held at LIMIT, and whether a conversion has begun
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      cyc <= 16'h0000;
      started <= 1'b0;
    end
    else
    begin
      if (cyc != 16'(LIMIT))
        cyc <= cyc + 16'h0001;
      if (conv_start_o)
        started <= 1'b1;
    end
  end
  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);
  sequence cfg_write;
    req_i.we && req_i.ptr == PTR_CFG1_WR;
  endsequence
  sequence halt_write;
    cfg_write ##0 req_i.wdata[CFG_HALT_BIT];
  endsequence
  chk_start_sets_busy: assert property (conv_start_o |-> conv_busy_o)
    else $error("busy low while a conversion starts");
  chk_done_drops_busy: assert property (conv_done_i && conv_busy_o |=> !conv_busy_o)
    else $error("busy still high after conversion end");
  chk_first_start: assert property (cyc == 16'(LIMIT) |-> started)
    else $error("no conversion started soon after reset");
  chk_range_follows: assert property (cfg_write |=> ##1
    extended_range_o == $past(req_i.wdata[CFG_RANGE_BIT], 2))
    else $error("range output differs from written bit");
  chk_cfg_reserved: assert property (req_i.re && req_i.ptr == PTR_CFG1_RD |=>
    (rdata_o & ~CFG1_WMASK) == 8'h00)
    else $error("reserved configuration bits read as one");
  chk_halt_aborts: assert property (halt_write |-> ##[1:2] !conv_busy_o)
    else $error("conversion not stopped by halt");
  chk_halt_no_start: assert property (conv_start_o |-> !cfg_q[CFG_HALT_BIT] || shot_q)
    else $error("conversion started while halted");
  chk_pin_open_drain: assert property (pin_o == 1'b0)
    else $error("pin driven high");
  chk_alert_release: assert property (alert_resp_i && !cfg_q[CFG_PINSEL_BIT] && !conv_done_i
    |-> ##[1:2] !pin_oe_o)
    else $error("attention pin not released by alert response");
  chk_mask_holds: assert property (cfg_d[CFG_MASK_BIT] && !cfg_d[CFG_PINSEL_BIT] &&
    cfg_q[CFG_MASK_BIT] && !cfg_q[CFG_PINSEL_BIT] |-> !pin_oe_o)
    else $error("masked attention pin pulled low");
  chk_read_stands: assert property (!$past(req_i.re) && !$past(req_i.re, 2) |->
    $stable(rdata_o))
    else $error("read data changed without a read");
endmodule

bind tms_status_cfg tms_status_checker #(.FIRST_DELAY(FIRST_DELAY)) u_chk (.clk_i(clk_i),
  .arst_n_i(arst_n_i), .req_i(req_i), .alert_resp_i(alert_resp_i),
  .alert_count_i(alert_count_i), .conv_done_i(conv_done_i), .result_i(result_i),
  .rdata_o(rdata_o), .conv_busy_o(conv_busy_o), .conv_start_o(conv_start_o),
  .extended_range_o(extended_range_o), .pin_o(pin_o), .pin_oe_o(pin_oe_o));

/* File: tb/tms_adc_model.sv */
// model: converter behind the block, answers each start after a fixed latency
`timescale 1ns/1ps
module tms_adc_model
  import tms_pkg::*;
#(
  parameter int LAT = 3
)
(
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic start_i,
  input wire tms_result_s res_i,
  output logic done_o,
  output tms_result_s result_o
);
  int cnt;
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      cnt <= 0;
      done_o <= 1'b0;
    end
    else
    begin
      done_o <= (cnt == 1);
      if (start_i)
        cnt <= LAT;
      else if (cnt > 0)
        cnt <= cnt - 1;
    end
  end
  // outside the done cycle the result lines carry garbage
  always_comb
  begin
    result_o = done_o ? res_i : ~res_i;
    if (!done_o)
      result_o.valid = 1'b0;
  end
endmodule

/* File: tb/tb_top.sv */
// testbench: register sequences against the status and configuration block
`timescale 1ns/1ps
module tb_top;
  import tms_pkg::*;
  logic clk_i = 1'b0;
  logic arst_n_i = 1'b0;
  tms_reg_req_s req_i = '0;
  logic alert_resp_i = 1'b0;
  logic [3:0] alert_count_i = 4'h1;
  logic conv_done_i;
  tms_result_s result_i;
  tms_result_s res = '{valid: 1'b1, remote: 1'b0, chan: 2'h0, open: 1'b0, temp: 8'h20,
    high_lim: 8'h7F, low_lim: 8'h00, crit_lim: 8'h7F};
  logic [7:0] rdata_o;
  logic conv_busy_o;
  logic conv_start_o;
  logic extended_range_o;
  logic pin_o;
  logic pin_oe_o;
  int bad_count = 0;
  int checked = 0;
  logic [7:0] v;

  tms_status_cfg #(.MERGED(1'b0), .FIRST_DELAY(4)) uut (.clk_i(clk_i), .arst_n_i(arst_n_i),
    .req_i(req_i), .alert_resp_i(alert_resp_i), .alert_count_i(alert_count_i),
    .conv_done_i(conv_done_i), .result_i(result_i), .rdata_o(rdata_o),
    .conv_busy_o(conv_busy_o), .conv_start_o(conv_start_o),
    .extended_range_o(extended_range_o), .pin_o(pin_o), .pin_oe_o(pin_oe_o));
  tms_adc_model #(.LAT(3)) adc (.clk_i(clk_i), .arst_n_i(arst_n_i), .start_i(conv_start_o),
    .res_i(res), .done_o(conv_done_i), .result_o(result_i));

  initial
  begin
    forever #12.5 clk_i = ~clk_i;
  end

  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task automatic finish_test();
    if (bad_count == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] p, input logic [7:0] d);
    @(posedge clk_i);
    req_i <= '{we: 1'b1, re: 1'b0, ptr: p, wdata: d};
    @(posedge clk_i);
    req_i.we <= 1'b0;
  endtask
  task automatic rchk(input logic [7:0] p, input logic [7:0] exp);
    @(posedge clk_i);
    req_i <= '{we: 1'b0, re: 1'b1, ptr: p, wdata: 8'h00};
    @(posedge clk_i);
    req_i.re <= 1'b0;
    @(posedge clk_i);
    #1;
    chk(rdata_o, exp);
  endtask
  // wait for a level on busy within a bound
  task automatic wait_busy(input logic lvl);
    int n;
    n = 0;
    while (conv_busy_o !== lvl)
    begin
      @(posedge clk_i);
      #1;
      n++;
      if (n > 60)
      begin
        bad_count++;
        finish_test();
      end
    end
  endtask
  // one single-shot conversion with the given result
  task automatic conv(input logic rem, input logic opn, input logic [7:0] t,
    input logic [7:0] hi, input logic [7:0] lo, input logic [7:0] cr);
    res.remote = rem;
    res.open = opn;
    res.temp = t;
    res.high_lim = hi;
    res.low_lim = lo;
    res.crit_lim = cr;
    wr(PTR_ONESHOT, 8'h01);
    wait_busy(1'b1);
    wait_busy(1'b0);
    repeat (2) @(posedge clk_i);
    #1;
  endtask
  task automatic alert_clr();
    @(posedge clk_i);
    alert_resp_i <= 1'b1;
    @(posedge clk_i);
    alert_resp_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    #1;
  endtask

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial
  begin
    repeat (8) @(posedge clk_i);
    arst_n_i <= 1'b1;
    rchk(PTR_CFG1_RD, CFG1_RST);
    rchk(PTR_HYST, HYST_RST);
    rchk(8'h55, 8'h00);
    wait_busy(1'b1);
    wr(PTR_CFG1_WR, 8'h40);
    repeat (3) @(posedge clk_i);
    #1;
    chk(8'(conv_busy_o), 8'h00);
    repeat (8) @(posedge clk_i);
    rchk(PTR_CFG1_RD, 8'h40);
    wr(PTR_CFG1_WR, 8'hFF);
    rchk(PTR_CFG1_RD, 8'hE4);
    chk(8'(extended_range_o), 8'h01);
    wr(PTR_CFG1_RD, 8'h40);
    rchk(PTR_CFG1_RD, 8'hE4);
    wr(PTR_STATUS, 8'hFF);
    rchk(PTR_STATUS, 8'h00);
    wr(PTR_CFG1_WR, 8'h40);
    @(posedge clk_i);
    #1;
    chk(8'(extended_range_o), 8'h00);
    alert_count_i <= 4'h0;
    conv(1'b0, 1'b1, 8'h20, 8'h7F, 8'h00, 8'h7F);
    rchk(PTR_STATUS, 8'h00);
    conv(1'b1, 1'b1, 8'h20, 8'h7F, 8'h00, 8'h7F);
    chk(8'(pin_oe_o), 8'h01);
    rchk(PTR_STATUS, 8'h04);
    rchk(PTR_STATUS, 8'h04);
    conv(1'b1, 1'b0, 8'h20, 8'h7F, 8'h00, 8'h7F);
    rchk(PTR_STATUS, 8'h04);
    rchk(PTR_STATUS, 8'h00);
    chk(8'(pin_oe_o), 8'h01);
    alert_clr();
    chk(8'(pin_oe_o), 8'h00);
    conv(1'b0, 1'b0, 8'h64, 8'h5A, 8'h00, 8'h7F);
    rchk(PTR_STATUS, 8'h40);
    conv(1'b0, 1'b0, 8'h5A, 8'h5A, 8'h00, 8'h7F);
    rchk(PTR_STATUS, 8'h40);
    rchk(PTR_STATUS, 8'h00);
    alert_clr();
    wr(PTR_CFG1_WR, 8'hC0);
    conv(1'b0, 1'b0, 8'h64, 8'h5A, 8'h00, 8'h7F);
    chk(8'(pin_oe_o), 8'h00);
    conv(1'b0, 1'b0, 8'h5A, 8'h5A, 8'h00, 8'h7F);
    rchk(PTR_STATUS, 8'h40);
    wr(PTR_CFG1_WR, 8'h40);
    conv(1'b0, 1'b0, 8'h05, 8'h7F, 8'h0A, 8'h7F);
    rchk(PTR_STATUS, 8'h20);
    conv(1'b0, 1'b0, 8'h0A, 8'h7F, 8'h0A, 8'h7F);
    rchk(PTR_STATUS, 8'h20);
    rchk(PTR_STATUS, 8'h00);
    conv(1'b0, 1'b0, 8'h7D, 8'h7F, 8'h00, 8'h78);
    rchk(PTR_STATUS, 8'h01);
    rchk(PTR_STATUS, 8'h01);
    conv(1'b0, 1'b0, 8'h73, 8'h7F, 8'h00, 8'h78);
    rchk(PTR_STATUS, 8'h01);
    conv(1'b0, 1'b0, 8'h6E, 8'h7F, 8'h00, 8'h78);
    rchk(PTR_STATUS, 8'h00);
    conv(1'b1, 1'b0, 8'h7D, 8'h7F, 8'h00, 8'h78);
    rchk(PTR_STATUS, 8'h02);
    conv(1'b1, 1'b0, 8'h6E, 8'h7F, 8'h00, 8'h78);
    alert_clr();
    alert_count_i <= 4'h2;
    conv(1'b0, 1'b0, 8'h05, 8'h7F, 8'h0A, 8'h7F);
    chk(8'(pin_oe_o), 8'h00);
    conv(1'b0, 1'b0, 8'h05, 8'h7F, 8'h0A, 8'h7F);
    chk(8'(pin_oe_o), 8'h01);
    alert_clr();
    conv(1'b0, 1'b0, 8'h20, 8'h7F, 8'h0A, 8'h7F);
    conv(1'b0, 1'b0, 8'h05, 8'h7F, 8'h0A, 8'h7F);
    chk(8'(pin_oe_o), 8'h00);
    conv(1'b0, 1'b0, 8'h20, 8'h7F, 8'h0A, 8'h7F);
    rchk(PTR_STATUS, 8'h20);
    alert_count_i <= 4'h0;
    wr(PTR_CFG1_WR, 8'h60);
    conv(1'b1, 1'b0, 8'h64, 8'h5A, 8'h00, 8'h7F);
    rchk(PTR_STATUS, 8'h10);
    chk(8'(pin_oe_o), 8'h01);
    conv(1'b1, 1'b0, 8'h55, 8'h5A, 8'h00, 8'h7F);
    rchk(PTR_STATUS, 8'h10);
    conv(1'b1, 1'b0, 8'h50, 8'h5A, 8'h00, 8'h7F);
    rchk(PTR_STATUS, 8'h00);
    chk(8'(pin_oe_o), 8'h00);
    wr(PTR_CFG1_WR, 8'h00);
    wait_busy(1'b1);
    finish_test();
  end
endmodule
